/* File: design/ptg_defs.vh */
// constants for the upper-address general-purpose port
// Behaviour
// - modes one to four drive upper address
// - mode five: direction one address, zero input
// - modes six, seven: direction selects output/input
// - modes one to four: direction fixed ones
// - modes five to seven: direction writable, reads ones
// - hw standby loads direction by mode; reset loads zeros
// - software standby keeps output pins driven
// - general output drives latch bit
// - data read: latch if output, else pin
// - reset/hw standby clears output latch
// - pull-up on: control one, direction zero
// - pull-ups off in modes 1-4, reset, hw standby
// - pull-up control register clears on reset
// - one direction bit per pin
`ifndef PTG_DEFS_VH
`define PTG_DEFS_VH
`define PTG_ADDR_W 20
`define PTG_OFS_DIR 20'hEE001
`define PTG_OFS_DATA 20'hFFFD1
`define PTG_OFS_PULL 20'hEE03C
`define PTG_DIR_RST_EXP 8'hFF
`define PTG_DIR_RST_GEN 8'h00
`define PTG_DATA_RST 8'h00
`define PTG_PULL_RST 8'h00
`define PTG_DIR_READ 8'hFF
`define PTG_UNMAPPED_READ 8'h00
`define PTG_OUT_RST 8'h00
`define PTG_MODE_W 3
`endif

/* File: design/ptg_port.v */
// upper-address / general-purpose port with direction, latch and pull-ups
`timescale 1ns/100ps
`default_nettype none
`include "ptg_defs.vh"
module ptg_port
(
    input wire sys_clk,
    input wire rst_b,
    input wire [`PTG_MODE_W-1:0] op_mode,
    input wire hw_standby,
    input wire sw_standby,
    input wire [`PTG_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] upper_address,
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    output reg [7:0] pullup_on
);

// mode class decoding used in several places
function is_expanded;
    input [`PTG_MODE_W-1:0] m;
    begin
        is_expanded = (m >= 3'h1) && (m <= 3'h4);
    end
endfunction

function is_mode5;
    input [`PTG_MODE_W-1:0] m;
    begin
        is_mode5 = (m == 3'h5);
    end
endfunction

// register address match
function reg_hit;
    input [`PTG_ADDR_W-1:0] a;
    input [`PTG_ADDR_W-1:0] ofs;
    begin
        reg_hit = (a == ofs);
    end
endfunction

// direction value loaded on initialisation
function [7:0] dir_init;
    input exp;
    begin
        if (exp)
        begin
            dir_init = `PTG_DIR_RST_EXP;
        end
        else
        begin
            dir_init = `PTG_DIR_RST_GEN;
        end
    end
endfunction

reg [7:0] pin_direction_select_r;
reg [7:0] output_data_latch_r;
reg [7:0] pullup_enable_select_r;
reg [7:0] pin_meta_r;
reg [7:0] pin_sync_r;
reg hw_meta_r;
reg hw_sync_r;
reg sw_meta_r;
reg sw_sync_r;
reg [`PTG_MODE_W-1:0] mode_meta_r;
reg [`PTG_MODE_W-1:0] mode_sync_r;
reg [7:0] reg_rdata_nxt;
wire [7:0] pin_out_nxt;
wire [7:0] pin_oe_nxt;
wire [7:0] pullup_on_nxt;
wire [7:0] data_read_val;
wire expanded;
wire mode5;
wire gen_io;
wire hit_dir;
wire hit_data;
wire hit_pull;
wire dir_we;
wire data_we;
wire pull_we;
genvar gi;

assign expanded = is_expanded(mode_sync_r);
assign mode5 = is_mode5(mode_sync_r);
assign gen_io = !expanded && !mode5;
assign hit_dir = reg_hit(reg_addr, `PTG_OFS_DIR);
assign hit_data = reg_hit(reg_addr, `PTG_OFS_DATA);
assign hit_pull = reg_hit(reg_addr, `PTG_OFS_PULL);

// write enables, all blocked in hardware standby
assign dir_we = reg_wr && hit_dir && !expanded && !hw_sync_r;
assign data_we = reg_wr && hit_data && !hw_sync_r;
assign pull_we = reg_wr && hit_pull && !hw_sync_r;

// pin synchroniser
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pin_meta_r <= 8'h00;
        pin_sync_r <= 8'h00;
    end
    else
    begin
        pin_meta_r <= pin_in;
        pin_sync_r <= pin_meta_r;
    end
end

// hardware standby synchroniser
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        hw_meta_r <= 1'b0;
        hw_sync_r <= 1'b0;
    end
    else
    begin
        hw_meta_r <= hw_standby;
        hw_sync_r <= hw_meta_r;
    end
end

// software standby synchroniser
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        sw_meta_r <= 1'b0;
        sw_sync_r <= 1'b0;
    end
    else
    begin
        sw_meta_r <= sw_standby;
        sw_sync_r <= sw_meta_r;
    end
end

// operating mode synchroniser
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        mode_meta_r <= 3'h0;
        mode_sync_r <= 3'h0;
    end
    else
    begin
        mode_meta_r <= op_mode;
        mode_sync_r <= mode_meta_r;
    end
end

// direction register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pin_direction_select_r <= `PTG_DIR_RST_GEN;
    end
    else if (hw_sync_r)
    begin
        // hardware standby reinitialises; software standby retains
        pin_direction_select_r <= dir_init(expanded);
    end
    else if (expanded)
    begin
        pin_direction_select_r <= `PTG_DIR_RST_EXP;
    end
    else if (dir_we)
    begin
        pin_direction_select_r <= reg_wdata;
    end
end

// output data latch
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        output_data_latch_r <= `PTG_DATA_RST;
    end
    else if (hw_sync_r)
    begin
        output_data_latch_r <= `PTG_DATA_RST;
    end
    else if (data_we)
    begin
        output_data_latch_r <= reg_wdata;
    end
end

// pull-up control register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pullup_enable_select_r <= `PTG_PULL_RST;
    end
    else if (hw_sync_r)
    begin
        pullup_enable_select_r <= `PTG_PULL_RST;
    end
    else if (pull_we)
    begin
        pullup_enable_select_r <= reg_wdata;
    end
end

// data read view per pin
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_rd
        assign data_read_val[gi] = pin_direction_select_r[gi] ? output_data_latch_r[gi] : pin_sync_r[gi];
    end
endgenerate

// read data, one cycle after the strobe, zero otherwise
always @*
begin
    reg_rdata_nxt = 8'h00;
    if (reg_rd)
    begin
        if (hit_dir)
        begin
            reg_rdata_nxt = `PTG_DIR_READ;
        end
        else if (hit_data)
        begin
            reg_rdata_nxt = data_read_val;
        end
        else if (hit_pull)
        begin
            reg_rdata_nxt = pullup_enable_select_r;
        end
        else
        begin
            reg_rdata_nxt = `PTG_UNMAPPED_READ;
        end
    end
end

// per-pin drive and pull-ups
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
        reg out_bit;
        reg oe_bit;
        reg pu_bit;
        always @*
        begin
            out_bit = 1'b0;
            oe_bit = 1'b0;
            pu_bit = 1'b0;
            if (hw_sync_r)
            begin
                oe_bit = 1'b0;
                pu_bit = 1'b0;
            end
            else if (expanded)
            begin
                out_bit = upper_address[gi];
                oe_bit = 1'b1;
            end
            else if (mode5)
            begin
                out_bit = upper_address[gi];
                oe_bit = pin_direction_select_r[gi];
                pu_bit = pullup_enable_select_r[gi] & ~pin_direction_select_r[gi];
            end
            else if (gen_io && sw_sync_r)
            begin
                out_bit = output_data_latch_r[gi];
                oe_bit = pin_direction_select_r[gi];
                pu_bit = pullup_enable_select_r[gi] & ~pin_direction_select_r[gi];
            end
            else
            begin
                out_bit = output_data_latch_r[gi];
                oe_bit = pin_direction_select_r[gi];
                pu_bit = pullup_enable_select_r[gi] & ~pin_direction_select_r[gi];
            end
        end
        assign pin_out_nxt[gi] = out_bit;
        assign pin_oe_nxt[gi] = oe_bit;
        assign pullup_on_nxt[gi] = pu_bit;
    end
endgenerate

// read data register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        reg_rdata <= `PTG_OUT_RST;
    end
    else
    begin
        reg_rdata <= reg_rdata_nxt;
    end
end

// pin drive value register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pin_out <= `PTG_OUT_RST;
    end
    else
    begin
        pin_out <= pin_out_nxt;
    end
end

// pin drive enable register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pin_oe <= `PTG_OUT_RST;
    end
    else
    begin
        pin_oe <= pin_oe_nxt;
    end
end

// pull-up enable register
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pullup_on <= `PTG_OUT_RST;
    end
    else
    begin
        pullup_on <= pullup_on_nxt;
    end
end

endmodule // ptg_port
`default_nettype wire

/* File: verif/ptg_port_asserts.sv */
// upper-address port checker
`timescale 1ns/100ps
`default_nettype none
`include "ptg_defs.vh"
module ptg_port_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] op_mode,
    input wire logic hw_standby,
    input wire logic [19:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] upper_address,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire xm = op_mode >= 3'h1 && op_mode <= 3'h4 && !hw_standby;
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
    a_dir_read: assert property ($past(reg_rd) && $past(reg_addr) == `PTG_OFS_DIR |-> reg_rdata == 8'hFF)
        else $error("dir");
    a_pull_oe: assert property ((pullup_on & pin_oe) == 8'h00) else $error("pu");
    a_exp_oe: assert property (xm [*6] |-> pin_oe == 8'hFF && pullup_on == 8'h00) else $error("xoe");
    a_exp_addr: assert property (xm [*6] |-> pin_out == $past(upper_address)) else $error("xa");
    a_hw_off: assert property (hw_standby [*5] |-> pin_oe == 8'h00 && pullup_on == 8'h00) else $error("hw");
    a_m5_addr: assert property ((op_mode == 3'h5) [*4] |-> ((pin_out ^ $past(upper_address)) & pin_oe) == 8'h00)
        else $error("m5");
    a_data_rd: assert property (op_mode >= 3'h6 && $past(reg_rd) && $past(reg_addr) == `PTG_OFS_DATA
        |-> ((reg_rdata ^ pin_out) & pin_oe) == 8'h00) else $error("rd");
endmodule // ptg_port_asserts
`default_nettype wire

/* File: verif/ptg_pins.sv */
// pin-side model: board drive, pull-ups, floating lines
`timescale 1ns/100ps
`default_nettype none
module ptg_pins (
    input wire logic clk,
    input wire logic [7:0] drv,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] ext,
    input wire logic [7:0] ext_oe,
    output logic [7:0] lvl
);
    logic [7:0] flt = 8'h5A;
    always @(posedge clk) flt <= ~flt;
    assign lvl = oe & drv | ~oe & (ext_oe & ext | ~ext_oe & (pu | flt));
endmodule // ptg_pins
`default_nettype wire

/* File: verif/ptg_port_tb_top.sv */
// bench for the upper-address port
`timescale 1ns/100ps
`default_nettype none
`include "ptg_defs.vh"
module ptg_port_tb_top;
    logic sys_clk = 1'h0, rst_b = 1'h0, hw = 1'h0, sw = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [2:0] md = 3'h6;
    logic [19:0] adr = 20'h0;
    logic [7:0] wd = 8'h0, ua = 8'h5A, ext = 8'hA5, eoe = 8'hFF;
    wire [7:0] rdat, pin, pout, poe, pu;
    int miscompares = 0, cmp_count = 0;
    ptg_port u_ptg_port (.sys_clk(sys_clk), .rst_b(rst_b), .op_mode(md), .hw_standby(hw), .sw_standby(sw),
        .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .upper_address(ua),
        .pin_in(pin), .pin_out(pout), .pin_oe(poe), .pullup_on(pu));
    ptg_pins u_ptg_pins (.clk(sys_clk), .drv(pout), .oe(poe), .pu(pu), .ext(ext), .ext_oe(eoe), .lvl(pin));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wrr(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {wr, adr, wd} <= {1'h1, a, d};
        @(posedge sys_clk);
        wr <= 1'h0;
    endtask
    task automatic rdc(input logic [19:0] a, input logic [7:0] e, input string n);
        @(posedge sys_clk);
        {rd, adr} <= {1'h1, a};
        @(posedge sys_clk);
        rd <= 1'h0;
        @(posedge sys_clk);
        chk(n, rdat, e);
    endtask
    task automatic rstm(input logic [2:0] m);
        rst_b <= 1'h0;
        md <= m;
        cyc(20);
        rst_b <= 1'h1;
        cyc(6);
    endtask
    task automatic t_gp;
        rdc(`PTG_OFS_DATA, 8'hA5, "din");
        rdc(`PTG_OFS_PULL, 8'h00, "pcr");
        rdc(20'h00000, 8'h00, "unmapped");
        wrr(`PTG_OFS_DIR, 8'h0F);
        wrr(`PTG_OFS_DATA, 8'h3C);
        wrr(`PTG_OFS_PULL, 8'hFF);
        eoe <= 8'hF0;
        cyc(4);
        chk("oe", poe, 8'h0F);
        chk("out", pout & 8'h0F, 8'h0C);
        chk("pu", pu, 8'hF0);
        rdc(`PTG_OFS_DATA, 8'hAC, "mix");
        rdc(`PTG_OFS_DIR, 8'hFF, "dir");
        sw <= 1'h1;
        cyc(5);
        chk("swoe", poe, 8'h0F);
        chk("swpu", pu, 8'hF0);
        sw <= 1'h0;
        hw <= 1'h1;
        cyc(5);
        chk("hwoe", poe, 8'h00);
        chk("hwpu", pu, 8'h00);
        hw <= 1'h0;
        cyc(4);
        rdc(`PTG_OFS_PULL, 8'h00, "hwpcr");
        wrr(`PTG_OFS_DIR, 8'hFF);
        rdc(`PTG_OFS_DATA, 8'h00, "hwlat");
        $display("t_gp done");
    endtask
    task automatic t_m5;
        rstm(3'h5);
        wrr(`PTG_OFS_DIR, 8'hF0);
        cyc(3);
        chk("m5oe", poe, 8'hF0);
        chk("m5out", pout & 8'hF0, 8'h50);
        $display("t_m5 done");
    endtask
    task automatic t_exp;
        for (int m = 1; m < 5; m++)
        begin
            rstm(3'(m));
            wrr(`PTG_OFS_DIR, 8'h00);
            wrr(`PTG_OFS_PULL, 8'hFF);
            cyc(3);
            chk("xoe", poe, 8'hFF);
            chk("xout", pout, ua);
            chk("xpu", pu, 8'h00);
        end
        $display("t_exp done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        rstm(3'h6);
        t_gp;
        t_m5;
        t_exp;
        finish_test;
    end
    initial
    begin
        cyc(3000);
        miscompares++;
        finish_test;
    end
endmodule // ptg_port_tb_top
bind ptg_port ptg_port_asserts u_ptg_port_asserts (.sys_clk(sys_clk), .rst_b(rst_b), .op_mode(op_mode),
    .hw_standby(hw_standby), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upper_address(upper_address), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));
`default_nettype wire
